/* File: inc/pfm_pkg.sv */
package pfm_pkg;
    localparam int          PFM_NPINS          = 8;
    localparam int          PFM_NFUNC_PINS     = 5;
    // byte address of the function-select register
    localparam logic [15:0] PFM_FSEL_ADDR      = 16'hf234;
    // per-pin drive and direction, gathered into registers at chosen offsets
    localparam logic [15:0] PFM_DRIVE_ADDR     = 16'hf238;
    localparam logic [15:0] PFM_DIR_ADDR       = 16'hf23c;
    localparam logic [15:0] PFM_DATA_ADDR      = 16'hf240;
    localparam logic [15:0] PFM_FSEL_RESET     = 16'h0000;
    localparam logic [15:0] PFM_DRIVE_RESET    = 16'h0000;
    localparam logic [7:0]  PFM_DIR_RESET      = 8'h00;
    localparam logic [7:0]  PFM_DATA_RESET     = 8'h00;
    localparam int          PFM_HI_BIT_OFFSET  = 8;
    // function codes
    localparam logic [1:0]  PFM_FN_GPIO        = 2'h0;
    localparam logic [1:0]  PFM_FN_SECOND      = 2'h1;
    localparam logic [1:0]  PFM_FN_THIRD       = 2'h2;
    localparam logic [1:0]  PFM_FN_FOURTH      = 2'h3;
    // drive codes
    localparam logic [1:0]  PFM_DRV_HIZ        = 2'h0;
    localparam logic [1:0]  PFM_DRV_PCH        = 2'h1;
    localparam logic [1:0]  PFM_DRV_NCH        = 2'h2;
    localparam logic [1:0]  PFM_DRV_CMOS       = 2'h3;
    localparam logic        PFM_DIR_OUT        = 1'b0;
endpackage

/* File: inc/pfm_pin_if.sv */
`timescale 1ns/1ps
`default_nettype none
// one pin's resolved source and configuration, fed to the pad cell
interface pfm_pin_if;
    logic       dir;
    logic [1:0] drive;
    logic       src_val;
    logic       src_oe;
    logic       forced_low;
    logic       pad_o;
    logic       pad_oe;
    logic       pull_up;
    logic       pull_dn;
    modport mux (output dir, drive, src_val, src_oe, forced_low, input pad_o, pad_oe, pull_up, pull_dn);
    modport pad (input dir, drive, src_val, src_oe, forced_low, output pad_o, pad_oe, pull_up, pull_dn);
endinterface
`default_nettype wire

/* File: rtl/pfm_pad_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
// turns a drive type and a wanted level into pad enable and pulls
module pfm_pad_ctrl
    import pfm_pkg::*;
(
    pfm_pin_if.pad p
);
    wire       is_out  = (p.dir == PFM_DIR_OUT);
    wire       lvl     = p.forced_low ? 1'b0 : p.src_val;
    wire       active  = p.forced_low | p.src_oe;
    wire       drv_hi  = (p.drive == PFM_DRV_PCH) | (p.drive == PFM_DRV_CMOS);
    wire       drv_lo  = (p.drive == PFM_DRV_NCH) | (p.drive == PFM_DRV_CMOS);
    // an open-drain type only ever drives its own level; the other level floats
    assign p.pad_o   = lvl;
    assign p.pad_oe  = is_out & active & (lvl ? drv_hi : drv_lo);
    assign p.pull_dn = ~is_out & (p.drive == PFM_DRV_PCH);
    assign p.pull_up = ~is_out & (p.drive == PFM_DRV_NCH);
endmodule
`default_nettype wire

/* File: rtl/pfm_port_mux.sv */
// Chosen here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - output direction: drive 00 float, 01 p open drain, 10 n open drain, 11 push-pull.
// - input direction: drive 00 float, 01 pull-down, 10 pull-up, 11 float.
// - direction bit 0 selects output encoding, 1 selects input encoding.
// - function-select register at f234, reset 0000, byte and halfword writable.
// - pin n function code is bit n+8 high and bit n low.
// - code 00 gives gpio and external interrupt; reset state.
// - pin 0: 01 i2c0 data, 10 sync tx, 11 uart rx.
// - pin 1: 01 i2c0 clock, 10 sync rx, 11 uart tx.
// - pin 2: 01 prohibited, 10 sync clock, 11 timer output eight.
// - pin 3: 01 melody, 10 prohibited, 11 timer output nine.
// - pin 4: 01 i2c1 data, 10 fifo sync tx, 11 fifo uart rx.
// - prohibited code in output mode ignores data; float or forced low.
// - gpio output drives data bit; input mode reads back sampled pin.
module pfm_port_mux
    import pfm_pkg::*;
(
    // system
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // wishbone classic slave
    input  wire logic                   cyc_i,
    input  wire logic                   stb_i,
    input  wire logic                   we_i,
    input  wire logic [15:0]            adr_i,
    input  wire logic [3:0]             sel_i,
    input  wire logic [31:0]            dat_i,
    output logic      [31:0]            dat_o,
    output logic                        ack_o,
    // pads
    input  wire logic [PFM_NPINS-1:0]   pad_i,
    output logic      [PFM_NPINS-1:0]   pad_o,
    output logic      [PFM_NPINS-1:0]   pad_oe_o,
    output logic      [PFM_NPINS-1:0]   pull_up_o,
    output logic      [PFM_NPINS-1:0]   pull_dn_o,
    // external interrupt inputs, synchronised pin level
    output logic      [PFM_NPINS-1:0]   ext_irq_o,
    // peripheral outputs toward pins
    input  wire logic                   i2c_chan0_data_out_i,
    input  wire logic                   i2c_chan0_clock_out_i,
    input  wire logic                   i2c_chan1_data_out_i,
    input  wire logic                   sync_serial_tx_i,
    input  wire logic                   sync_serial_clk_out_i,
    input  wire logic                   sync_serial_clk_oe_i,
    input  wire logic                   uart_tx_pin_i,
    input  wire logic                   fifo_serial_tx_i,
    input  wire logic                   melody_buzzer_out_i,
    input  wire logic                   function_timer_out_eight_i,
    input  wire logic                   function_timer_out_nine_i,
    // pin levels toward peripherals
    output logic                        i2c_chan0_data_in_o,
    output logic                        i2c_chan0_clock_in_o,
    output logic                        i2c_chan1_data_in_o,
    output logic                        sync_serial_rx_o,
    output logic                        sync_serial_clk_in_o,
    output logic                        uart_rx_pin_o,
    output logic                        fifo_uart_rx_o
);
    import pfm_pkg::*;

    logic [15:0]          fsel_reg;
    logic [15:0]          drive_reg;
    logic [7:0]           dir_reg;
    logic [7:0]           data_reg;
    logic [PFM_NPINS-1:0] sync1_reg;
    logic [PFM_NPINS-1:0] sync2_reg;
    logic                 ack_reg;
    logic [31:0]          rdat_reg;

    // i2c pins are open drain: enable only while pulling low
    logic [PFM_NPINS-1:0] alt_val;
    logic [PFM_NPINS-1:0] alt_oe;
    logic [PFM_NPINS-1:0] prohib;
    logic [PFM_NPINS-1:0] gpio_sel;
    logic [PFM_NPINS-1:0] pad_o_w;
    logic [PFM_NPINS-1:0] pad_oe_w;
    logic [PFM_NPINS-1:0] pu_w;
    logic [PFM_NPINS-1:0] pd_w;

    function automatic logic [1:0] fcode(input logic [15:0] r, input int n);
        fcode = {r[n+PFM_HI_BIT_OFFSET], r[n]};
    endfunction

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // bus decode
    wire        req      = cyc_i & stb_i & ~ack_reg;
    // a write lands on the edge at which the master sees ack, with its data still held
    wire        wr       = cyc_i & stb_i & ack_reg & we_i;
    wire        hit_fsel = (adr_i == PFM_FSEL_ADDR);
    wire        hit_drv  = (adr_i == PFM_DRIVE_ADDR);
    wire        hit_dir  = (adr_i == PFM_DIR_ADDR);
    wire        hit_data = (adr_i == PFM_DATA_ADDR);
    // input mode reads the sampled pin, output mode reads the data register
    wire [7:0]  data_rd  = (dir_reg & sync2_reg) | (~dir_reg & data_reg);
    wire [31:0] rd_mux   = hit_fsel ? {16'h0000, fsel_reg} :
                           hit_drv  ? {16'h0000, drive_reg} :
                           hit_dir  ? {24'h000000, dir_reg} :
                           hit_data ? {24'h000000, data_rd} : 32'h00000000;

    wire [15:0] fsel_next  = (wr & hit_fsel) ? merge16(fsel_reg, dat_i, sel_i) : fsel_reg;
    wire [15:0] drive_next = (wr & hit_drv) ? merge16(drive_reg, dat_i, sel_i) : drive_reg;
    wire [7:0]  dir_next   = (wr & hit_dir & sel_i[0]) ? dat_i[7:0] : dir_reg;
    wire [7:0]  data_next  = (wr & hit_data & sel_i[0]) ? dat_i[7:0] : data_reg;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fsel_reg  <= PFM_FSEL_RESET;
            drive_reg <= PFM_DRIVE_RESET;
            dir_reg   <= PFM_DIR_RESET;
            data_reg  <= PFM_DATA_RESET;
            ack_reg   <= 1'b0;
            rdat_reg  <= 32'h00000000;
        end
        else
        begin
            fsel_reg  <= fsel_next;
            drive_reg <= drive_next;
            dir_reg   <= dir_next;
            data_reg  <= data_next;
            ack_reg   <= req;
            rdat_reg  <= req ? rd_mux : 32'h00000000;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= pad_i;
            sync2_reg <= sync1_reg;
        end
    end

    // per-pin function routing
    wire [1:0] c0 = fcode(fsel_reg, 0);
    wire [1:0] c1 = fcode(fsel_reg, 1);
    wire [1:0] c2 = fcode(fsel_reg, 2);
    wire [1:0] c3 = fcode(fsel_reg, 3);
    wire [1:0] c4 = fcode(fsel_reg, 4);

    assign alt_val[0] = (c0 == PFM_FN_SECOND) ? i2c_chan0_data_out_i : sync_serial_tx_i;
    assign alt_oe[0]  = (c0 == PFM_FN_SECOND) ? ~i2c_chan0_data_out_i : (c0 == PFM_FN_THIRD);
    assign alt_val[1] = (c1 == PFM_FN_SECOND) ? i2c_chan0_clock_out_i : uart_tx_pin_i;
    assign alt_oe[1]  = (c1 == PFM_FN_SECOND) ? ~i2c_chan0_clock_out_i : (c1 == PFM_FN_FOURTH);
    assign alt_val[2] = (c2 == PFM_FN_THIRD) ? sync_serial_clk_out_i : function_timer_out_eight_i;
    assign alt_oe[2]  = (c2 == PFM_FN_THIRD) ? sync_serial_clk_oe_i : 1'b1;
    assign alt_val[3] = (c3 == PFM_FN_SECOND) ? melody_buzzer_out_i : function_timer_out_nine_i;
    assign alt_oe[3]  = 1'b1;
    assign alt_val[4] = (c4 == PFM_FN_SECOND) ? i2c_chan1_data_out_i : fifo_serial_tx_i;
    assign alt_oe[4]  = (c4 == PFM_FN_SECOND) ? ~i2c_chan1_data_out_i : (c4 == PFM_FN_THIRD);
    // function codes of pins 5 to 7 are not routed here; those pins stay gpio
    assign alt_val[7:5] = '0;
    assign alt_oe[7:5]  = '0;

    assign prohib[2]   = (c2 == PFM_FN_SECOND);
    assign prohib[3]   = (c3 == PFM_FN_THIRD);
    assign prohib[1:0] = '0;
    assign prohib[7:4] = '0;

    genvar g;
    generate
        for (g = 0; g < PFM_NPINS; g++)
        begin : g_pin
            pfm_pin_if pin ();
            if (g < PFM_NFUNC_PINS)
            begin : g_fn
                assign gpio_sel[g] = (fcode(fsel_reg, g) == PFM_FN_GPIO);
            end
            else
            begin : g_plain
                assign gpio_sel[g] = 1'b1;
            end
            assign pin.dir        = dir_reg[g];
            assign pin.drive      = {drive_reg[g+PFM_HI_BIT_OFFSET], drive_reg[g]};
            assign pin.forced_low = prohib[g] & ~gpio_sel[g];
            assign pin.src_val    = gpio_sel[g] ? data_reg[g] : alt_val[g];
            assign pin.src_oe     = gpio_sel[g] ? 1'b1 : alt_oe[g];
            pfm_pad_ctrl u_pad (
                .p (pin)
            );
            assign pad_o_w[g]  = pin.pad_o;
            assign pad_oe_w[g] = pin.pad_oe;
            assign pu_w[g]     = pin.pull_up;
            assign pd_w[g]     = pin.pull_dn;
        end
    endgenerate

    // registered outputs: pads change one cycle after configuration
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pad_o     <= '0;
            pad_oe_o  <= '0;
            pull_up_o <= '0;
            pull_dn_o <= '0;
        end
        else
        begin
            pad_o     <= pad_o_w;
            pad_oe_o  <= pad_oe_w;
            pull_up_o <= pu_w;
            pull_dn_o <= pd_w;
        end
    end

    // receive paths: an unselected receiver sees an idle high line, so a
    // gpio toggling on the shared pin never looks like traffic to it
    wire                 i2c0_dat_in_w = (c0 == PFM_FN_SECOND) ? sync2_reg[0] : 1'b1;
    wire                 i2c0_clk_in_w = (c1 == PFM_FN_SECOND) ? sync2_reg[1] : 1'b1;
    wire                 i2c1_dat_in_w = (c4 == PFM_FN_SECOND) ? sync2_reg[4] : 1'b1;
    wire                 ser_rx_in_w   = (c1 == PFM_FN_THIRD) ? sync2_reg[1] : 1'b1;
    wire                 ser_clk_in_w  = (c2 == PFM_FN_THIRD) ? sync2_reg[2] : 1'b1;
    wire                 uart_rx_in_w  = (c0 == PFM_FN_FOURTH) ? sync2_reg[0] : 1'b1;
    wire                 fifo_rx_in_w  = (c4 == PFM_FN_FOURTH) ? sync2_reg[4] : 1'b1;
    // external interrupts only listen while the pin is in its primary function
    wire [PFM_NPINS-1:0] irq_in_w      = sync2_reg & gpio_sel;

    // pin levels toward peripherals, one register after the synchroniser;
    // the extra cycle of latency is the price of flip-flop outputs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ext_irq_o            <= '0;
            i2c_chan0_data_in_o  <= 1'b1;
            i2c_chan0_clock_in_o <= 1'b1;
            i2c_chan1_data_in_o  <= 1'b1;
            sync_serial_rx_o     <= 1'b1;
            sync_serial_clk_in_o <= 1'b1;
            uart_rx_pin_o        <= 1'b1;
            fifo_uart_rx_o       <= 1'b1;
        end
        else
        begin
            ext_irq_o            <= irq_in_w;
            i2c_chan0_data_in_o  <= i2c0_dat_in_w;
            i2c_chan0_clock_in_o <= i2c0_clk_in_w;
            i2c_chan1_data_in_o  <= i2c1_dat_in_w;
            sync_serial_rx_o     <= ser_rx_in_w;
            sync_serial_clk_in_o <= ser_clk_in_w;
            uart_rx_pin_o        <= uart_rx_in_w;
            fifo_uart_rx_o       <= fifo_rx_in_w;
        end
    end

    // bus outputs come straight from their registers
    assign dat_o = rdat_reg;
    assign ack_o = ack_reg;

    // checker helpers: configuration of every pin, split by drive code
    wire [PFM_NPINS-1:0] drv_c0_w      = drive_reg[7:0];
    wire [PFM_NPINS-1:0] drv_c1_w      = drive_reg[15:8];
    wire [PFM_NPINS-1:0] out_hiz_w     = ~dir_reg & ~drv_c1_w & ~drv_c0_w;
    wire [PFM_NPINS-1:0] in_pull_up_w  = dir_reg & drv_c1_w & ~drv_c0_w;
    wire [PFM_NPINS-1:0] in_pull_dn_w  = dir_reg & ~drv_c1_w & drv_c0_w;
    // prohibited code: n-channel and push-pull hold low, the rest float
    wire [PFM_NPINS-1:0] prohib_low_w  = prohib & ~dir_reg & drv_c1_w;
    wire [PFM_NPINS-1:0] prohib_hiz_w  = prohib & ~dir_reg & ~drv_c1_w;

    // a bus request is answered by exactly one cycle of ack
    sequence bus_req_s;
        cyc_i && stb_i && !ack_o;
    endsequence

    sequence ack_pulse_s;
        ack_o ##1 !ack_o;
    endsequence

    bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i) bus_req_s |=> ack_pulse_s)
        else $error("bus request not answered by a single ack pulse");

    fsel_reset_a: assert property (@(posedge clk_i) rst_i |=> (fsel_reg == PFM_FSEL_RESET))
        else $error("function select not cleared by reset");

    // the checks below look one cycle back, since the pad outputs are registered
    out_hiz_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (pad_oe_o & $past(out_hiz_w)) == '0)
        else $error("high impedance output pin is driven");

    in_no_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (pad_oe_o & $past(dir_reg)) == '0)
        else $error("input pin is driven");

    pull_up_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pull_up_o == $past(in_pull_up_w))
        else $error("pull-up does not follow input drive code");

    pull_dn_a: assert property (@(posedge clk_i) disable iff (rst_i)
        pull_dn_o == $past(in_pull_dn_w))
        else $error("pull-down does not follow input drive code");

    prohib_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (pad_oe_o & ~pad_o & $past(prohib_low_w)) == $past(prohib_low_w))
        else $error("prohibited code pin not held low");

    prohib_hiz_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (pad_oe_o & $past(prohib_hiz_w)) == '0)
        else $error("prohibited code pin not floating");
endmodule
`default_nettype wire

/* File: tb/pfm_pad_model.sv */
`timescale 1ns/1ps
`default_nettype none
// board side of the port: external drivers, pulls and floating lines
module pfm_pad_model
(
    // system
    input  wire logic       clk_i,
    // block pads
    input  wire logic [7:0] pad_o_i,
    input  wire logic [7:0] pad_oe_i,
    input  wire logic [7:0] pull_up_i,
    input  wire logic [7:0] pull_dn_i,
    // board driver
    input  wire logic [7:0] ext_val_i,
    input  wire logic [7:0] ext_oe_i,
    // resolved pin level
    output logic      [7:0] lvl_o
);
    logic [7:0] last_reg = 8'h00;
    // a floating pin toggles so a stale level never passes as a match
    always_comb
    begin
        for (int n = 0; n < 8; n++)
        begin
            if (pad_oe_i[n])
                lvl_o[n] = pad_o_i[n];
            else if (ext_oe_i[n])
                lvl_o[n] = ext_val_i[n];
            else if (pull_up_i[n] | pull_dn_i[n])
                lvl_o[n] = pull_up_i[n];
            else
                lvl_o[n] = ~last_reg[n];
        end
    end
    always_ff @(posedge clk_i)
        last_reg <= lvl_o;
endmodule
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pfm_pkg::*;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, v;
    logic [15:0] adr_i, rd;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o;
    logic [7:0]  pad_i, pad_o, pad_oe_o, pull_up_o, pull_dn_o, ext_irq_o, ext_val, ext_oe, e;
    logic i2c_chan0_data_out_i, i2c_chan0_clock_out_i, i2c_chan1_data_out_i, sync_serial_tx_i, uart_tx_pin_i;
    logic sync_serial_clk_out_i, sync_serial_clk_oe_i, fifo_serial_tx_i, melody_buzzer_out_i;
    logic function_timer_out_eight_i, function_timer_out_nine_i, i2c_chan0_data_in_o, i2c_chan0_clock_in_o;
    logic i2c_chan1_data_in_o, sync_serial_rx_o, sync_serial_clk_in_o, uart_rx_pin_o, fifo_uart_rx_o;
    int err_total, checks_done;
    pfm_port_mux pfm_port_mux_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
        .ack_o, .pad_i, .pad_o, .pad_oe_o, .pull_up_o, .pull_dn_o, .ext_irq_o, .i2c_chan0_data_out_i,
        .i2c_chan0_clock_out_i, .i2c_chan1_data_out_i, .sync_serial_tx_i, .sync_serial_clk_out_i,
        .sync_serial_clk_oe_i, .uart_tx_pin_i, .fifo_serial_tx_i, .melody_buzzer_out_i,
        .function_timer_out_eight_i, .function_timer_out_nine_i, .i2c_chan0_data_in_o, .i2c_chan0_clock_in_o,
        .i2c_chan1_data_in_o, .sync_serial_rx_o, .sync_serial_clk_in_o, .uart_rx_pin_o, .fifo_uart_rx_o);
    pfm_pad_model pfm_pad_model_i (.clk_i, .pad_o_i(pad_o), .pad_oe_i(pad_oe_o), .pull_up_i(pull_up_o),
        .pull_dn_i(pull_dn_o), .ext_val_i(ext_val), .ext_oe_i(ext_oe), .lvl_o(pad_i));
    task automatic wb(input logic w, input logic [15:0] a, input logic [3:0] s, input logic [15:0] d);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, 16'h0000, d};
        do
            @(posedge clk_i);
        while (ack_o !== 1'b1);
        rd = dat_o[15:0];
        {cyc_i, stb_i} <= 2'b00;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic settle;
        repeat (5) @(posedge clk_i);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial
    begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        wrap_up;
    end
    initial
    begin
        {err_total, checks_done, v} = 0;
        {rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i, ext_val, ext_oe} = {1'b1, 71'h0};
        {i2c_chan0_data_out_i, i2c_chan0_clock_out_i, i2c_chan1_data_out_i, sync_serial_tx_i} = 4'h0;
        {uart_tx_pin_i, sync_serial_clk_out_i, fifo_serial_tx_i, melody_buzzer_out_i} = 4'h0;
        {function_timer_out_eight_i, function_timer_out_nine_i, sync_serial_clk_oe_i} = 3'b001;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, PFM_FSEL_ADDR, 4'h3, 0);
        chk(rd, PFM_FSEL_RESET);
        chk({pad_oe_o, pull_up_o | pull_dn_o}, 0);
        wb(1, PFM_FSEL_ADDR, 4'h1, 16'h005a);
        wb(1, PFM_FSEL_ADDR, 4'h2, 16'ha500);
        wb(0, PFM_FSEL_ADDR, 4'h3, 0);
        chk(rd, 16'ha55a);
        wb(0, 16'hf250, 4'h3, 0);
        chk(rd, 16'h0000);
        wb(1, PFM_FSEL_ADDR, 4'h3, 0);
        $display("test registers done");
        wb(1, PFM_DATA_ADDR, 4'h1, 16'h00c5);
        for (int d = 0; d < 4; d++)
        begin
            wb(1, PFM_DRIVE_ADDR, 4'h3, {{8{d[1]}}, {8{d[0]}}});
            settle;
            e = d == 0 ? 8'h00 : d == 1 ? 8'hc5 : d == 2 ? 8'h3a : 8'hff;
            chk(pad_oe_o, e);
            chk(pad_i & e, 8'hc5 & e);
        end
        wb(1, PFM_DIR_ADDR, 4'h1, 16'h00ff);
        for (int d = 0; d < 4; d++)
        begin
            wb(1, PFM_DRIVE_ADDR, 4'h3, {{8{d[1]}}, {8{d[0]}}});
            settle;
            chk({pad_oe_o, pull_dn_o, pull_up_o}, {8'h00, {8{d == 1}}, {8{d == 2}}});
        end
        wb(1, PFM_DRIVE_ADDR, 4'h3, 0);
        {ext_val, ext_oe} <= 16'h3cff;
        settle;
        wb(0, PFM_DATA_ADDR, 4'h1, 0);
        chk(rd[7:0], 8'h3c);
        chk(ext_irq_o, 8'h3c);
        $display("test gpio done");
        wb(1, PFM_DIR_ADDR, 4'h1, 0);
        wb(1, PFM_DRIVE_ADDR, 4'h3, 16'hffff);
        wb(1, PFM_DATA_ADDR, 4'h1, 16'h00ff);
        for (int c = 1; c < 4; c++)
        begin
            wb(1, PFM_FSEL_ADDR, 4'h3, {3'h0, {5{c[1]}}, 3'h0, {5{c[0]}}});
            for (int k = 0; k < 2; k++)
            begin
                v = k[0];
                {i2c_chan0_data_out_i, i2c_chan0_clock_out_i, i2c_chan1_data_out_i, sync_serial_tx_i} <= {4{v}};
                {uart_tx_pin_i, sync_serial_clk_out_i, fifo_serial_tx_i, melody_buzzer_out_i} <= {4{v}};
                {function_timer_out_eight_i, function_timer_out_nine_i} <= {2{v}};
                {ext_val, ext_oe} <= {{8{~v}}, 8'hff};
                settle;
                if (c == 1)
                begin
                    chk({pad_i[3:2], pad_oe_o[2]}, {v, 2'b01});
                    chk({i2c_chan0_data_in_o, i2c_chan0_clock_in_o, i2c_chan1_data_in_o}, 3'b000);
                end
                else if (c == 2)
                begin
                    chk({pad_i[0], pad_i[2], pad_i[4], pad_i[3], pad_oe_o[3]}, {v, v, v, 2'b01});
                    chk({sync_serial_rx_o, sync_serial_clk_in_o}, {~v, v});
                end
                else
                    chk({pad_i[3:1], uart_rx_pin_o, fifo_uart_rx_o}, {v, v, v, ~v, ~v});
            end
        end
        $display("test alternate functions done");
        wrap_up;
    end
endmodule
`default_nettype wire
